// file: ettc_params.svh
// Offsets, field positions, reset values and tuning constants of the external trip control.
`ifndef ETTC_PARAMS_SVH
`define ETTC_PARAMS_SVH

// Register indexes; the byte address is four times the index.
`define ETTC_CTRL_IDX      16'h10EF
`define ETTC_SCI_MASK_IDX  16'h10F0
`define ETTC_SMI_MASK_IDX  16'h10F1
`define ETTC_SERR_MASK_IDX 16'h10F2
`define ETTC_INTR_MASK_IDX 16'h10F3
`define ETTC_IRQ_STAT_IDX  16'h10F4
`define ETTC_IRQ_EN_IDX    16'h10F5
`define ETTC_IRQ_CLR_IDX   16'h10F6

// Control and status register fields.
`define ETTC_EN_BIT        7
`define ETTC_THR_TYPE_BIT  6
`define ETTC_ACT2_BIT      5
`define ETTC_ACT1_BIT      4
`define ETTC_TI0_BIT       3
`define ETTC_TI1_BIT       2
`define ETTC_ROUTE_BIT     0

// Event mask fields, one bit per trip class.
`define ETTC_MASK_CAT_BIT  5
`define ETTC_MASK_HOT_BIT  4
`define ETTC_MASK_AUX0_BIT 0

// Interrupt status fields.
`define ETTC_IRQ_FIRST_BIT  0
`define ETTC_IRQ_SECOND_BIT 1

// Reset values.
`define ETTC_CTRL_RST      8'h00
`define ETTC_MASK_RST      8'h00
`define ETTC_IRQ_RST       2'h0

// Synchroniser depth.
`define ETTC_SYNC_STAGES   2

`endif

// file: ettc_pkg.sv
// Types shared by the external trip control modules.
package ettc_pkg;

    typedef logic [7:0] ettc_byte_t;

    // One trip class set as seen by an internal sensor register set.
    typedef struct packed {
        logic cat;
        logic hot;
        logic aux0;
    } ettc_class_t;

endpackage

// file: ettc_reg_if.sv
// Register access channel between the bus slave and the register file.
`timescale 1ns/10ps
`default_nettype none

interface ettc_reg_if #(
    parameter int AW = 16
);
    logic              wr_stb;
    logic [AW-1:0]     addr;
    ettc_pkg::ettc_byte_t wdata;
    ettc_pkg::ettc_byte_t rdata;

    modport slv (
        output wr_stb,
        output addr,
        output wdata,
        input  rdata
    );

    modport regs (
        input  wr_stb,
        input  addr,
        input  wdata,
        output rdata
    );
endinterface

`default_nettype wire

// file: ettc_sensor_model.sv
// Behavioural pair of external temperature sensors driving active-low trip pins.
`timescale 1ns/10ps
`default_nettype none

module ettc_sensor_model (
    // Temperature state set by the bench
    input  wire logic over_first_i,
    input  wire logic over_second_i,
    // Trip pins, active low
    output logic      trip_first_n_o,
    output logic      trip_second_n_o
);
    // A sensor pulls its pin low only while its limit is exceeded.
    assign trip_first_n_o  = !over_first_i;
    assign trip_second_n_o = !over_second_i;
endmodule

`default_nettype wire

// file: ettc_sync.sv
// Multi-stage level synchroniser for asynchronous pins.
`timescale 1ns/10ps
`default_nettype none

module ettc_sync #(
    parameter int          W      = 2,
    parameter int          STAGES = 2,
    parameter logic [31:0] RST_V  = 32'h0000_0003
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] stage_r [STAGES];

    initial begin
        if (STAGES < 2 || W < 1 || W > 32) begin
            $error("ettc_sync: unsupported W or STAGES");
        end
    end

    // Only the next stage reads each stage, so metastability cannot fan out.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_r[i] <= RST_V[W-1:0];
            end
        end else begin
            stage_r[0] <= d_i;
            for (int i = 1; i < STAGES; i++) begin
                stage_r[i] <= stage_r[i-1];
            end
        end
    end

    assign q_o = stage_r[STAGES-1];

endmodule

`default_nettype wire

// file: ettc_top.sv
// External thermal trip control and status with Wishbone register access.
//
// Operation
// - Setting the enable bit 7 locks throttle type, both action selects and routing.
// - Only a hardware reset returns the enable and lock bit to zero.
// - Writing 0 to the enable bit once it is set leaves it at 1.
// - With the enable bit at 0 the trip pins drive only status bits 3 and 2, with 1 they are used.
// - A low level on either trip pin is an asserted trip that can start throttling.
// - An asserted trip raises SCI, SMI, SERR or INTR events through per-class masks.
// - Internal and external throttle requests are combined by a logical OR.
// - Throttle type bit 6 picks memory throttling at 0 and controller throttling at 1.
// - Action select bit 5 makes the second trip a hot trip at 0 and an aux0 trip at 1.
// - Action select bit 4 makes the first trip a catastrophic trip at 0 and hot at 1.
// - Status bits 3 and 2 read 1 while the first and second sensor report over limit.
// - Routing bit 0 steers trip effects to sensor set 1 at 0 and sensor set 2 at 1.
`include "ettc_params.svh"
`timescale 1ns/10ps
`default_nettype none

module ettc_top #(
    parameter int AW = 16
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [AW-1:0]        wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // External sensor trip pins, active low
    input  wire logic                 ext_trip_pin_first_n_i,
    input  wire logic                 ext_trip_pin_second_n_i,
    // Internal sensor throttle requests
    input  wire logic                 int_mem_throttle_i,
    input  wire logic                 int_ctl_throttle_i,
    // Throttle requests
    output logic                      mem_throttle_o,
    output logic                      ctl_throttle_o,
    // Trip classes per internal sensor register set
    output ettc_pkg::ettc_class_t     sensor1_trip_o,
    output ettc_pkg::ettc_class_t     sensor2_trip_o,
    // Event message pulses
    output logic                      sci_evt_o,
    output logic                      smi_evt_o,
    output logic                      serr_evt_o,
    output logic                      intr_evt_o,
    // Interrupt
    output logic                      irq_o
);
    import ettc_pkg::*;

    initial begin
        if (AW < 16) begin
            $error("ettc_top: AW must be at least 16");
        end
    end

    // Byte address of a register from its index.
    function automatic logic [AW-1:0] reg_addr(input logic [15:0] idx);
        logic [AW-1:0] a;
        a = '0;
        a[15:0] = {idx[13:0], 2'b00};
        return a;
    endfunction

    // Whether an enabled class of a mask is active.
    function automatic logic class_hit(input ettc_byte_t mask, input ettc_class_t c);
        return (mask[`ETTC_MASK_CAT_BIT] & c.cat) |
               (mask[`ETTC_MASK_HOT_BIT] & c.hot) |
               (mask[`ETTC_MASK_AUX0_BIT] & c.aux0);
    endfunction

    ettc_reg_if #(.AW(AW)) rif ();

    ettc_wb_slave #(
        .AW (AW)
    ) u_wb (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .rif      (rif.slv)
    );

    // Pins idle high, so the synchroniser resets to the released level.
    logic [1:0] pins_n_s;

    ettc_sync #(
        .W      (2),
        .STAGES (`ETTC_SYNC_STAGES),
        .RST_V  (32'h0000_0003)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({ext_trip_pin_second_n_i, ext_trip_pin_first_n_i}),
        .q_o   (pins_n_s)
    );

    // Control register state.
    logic enable_r;
    logic thr_type_r;
    logic act2_r;
    logic act1_r;
    logic route_r;
    ettc_byte_t sci_mask_r;
    ettc_byte_t smi_mask_r;
    ettc_byte_t serr_mask_r;
    ettc_byte_t intr_mask_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_en_r;

    logic wr_ctrl;
    logic wr_clr;
    assign wr_ctrl = rif.wr_stb && (rif.addr == reg_addr(`ETTC_CTRL_IDX));
    assign wr_clr  = rif.wr_stb && (rif.addr == reg_addr(`ETTC_IRQ_CLR_IDX));

    // The enable bit can only be set; it falls with reset alone.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_r <= 1'(`ETTC_CTRL_RST >> `ETTC_EN_BIT);
        end else if (wr_ctrl) begin
            enable_r <= enable_r | rif.wdata[`ETTC_EN_BIT];
        end
    end

    // The write that sets the enable bit still loads the lockable fields.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_type_r <= 1'b0;
            act2_r     <= 1'b0;
            act1_r     <= 1'b0;
            route_r    <= 1'b0;
        end else if (wr_ctrl && !enable_r) begin
            thr_type_r <= rif.wdata[`ETTC_THR_TYPE_BIT];
            act2_r     <= rif.wdata[`ETTC_ACT2_BIT];
            act1_r     <= rif.wdata[`ETTC_ACT1_BIT];
            route_r    <= rif.wdata[`ETTC_ROUTE_BIT];
        end
    end

    // Masks keep all eight bits for readback; only the catastrophic, hot and
    // aux0 positions reach the event logic, the rest are spare storage.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sci_mask_r  <= `ETTC_MASK_RST;
            smi_mask_r  <= `ETTC_MASK_RST;
            serr_mask_r <= `ETTC_MASK_RST;
            intr_mask_r <= `ETTC_MASK_RST;
            irq_en_r    <= `ETTC_IRQ_RST;
        end else if (rif.wr_stb) begin
            if (rif.addr == reg_addr(`ETTC_SCI_MASK_IDX)) begin
                sci_mask_r <= rif.wdata;
            end else if (rif.addr == reg_addr(`ETTC_SMI_MASK_IDX)) begin
                smi_mask_r <= rif.wdata;
            end else if (rif.addr == reg_addr(`ETTC_SERR_MASK_IDX)) begin
                serr_mask_r <= rif.wdata;
            end else if (rif.addr == reg_addr(`ETTC_INTR_MASK_IDX)) begin
                intr_mask_r <= rif.wdata;
            end else if (rif.addr == reg_addr(`ETTC_IRQ_EN_IDX)) begin
                irq_en_r <= rif.wdata[1:0];
            end
        end
    end

    // Trip detection and class mapping.
    logic raw_first;
    logic raw_second;
    logic trip_first;
    logic trip_second;
    ettc_class_t cls;
    logic ext_throttle;

    assign raw_first   = ~pins_n_s[0];
    assign raw_second  = ~pins_n_s[1];
    assign trip_first  = enable_r & raw_first;
    assign trip_second = enable_r & raw_second;

    assign cls.cat  = trip_first & ~act1_r;
    assign cls.hot  = (trip_first & act1_r) | (trip_second & ~act2_r);
    assign cls.aux0 = trip_second & act2_r;
    assign ext_throttle = cls.cat | cls.hot | cls.aux0;

    // Internal requests go straight into the OR, so a disabled or locked
    // external path can never mask a request from an internal sensor.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_throttle_o <= 1'b0;
            ctl_throttle_o <= 1'b0;
        end else begin
            mem_throttle_o <= (ext_throttle & ~thr_type_r) | int_mem_throttle_i;
            ctl_throttle_o <= (ext_throttle & thr_type_r) | int_ctl_throttle_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sensor1_trip_o <= '0;
            sensor2_trip_o <= '0;
        end else begin
            sensor1_trip_o <= route_r ? '0 : cls;
            sensor2_trip_o <= route_r ? cls : '0;
        end
    end

    // Events fire once per new class assertion rather than every cycle a
    // trip stays active, so a held pin does not flood the message path.
    ettc_class_t cls_prev_r;
    ettc_class_t cls_rise;
    assign cls_rise = cls & ~cls_prev_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cls_prev_r <= '0;
            sci_evt_o  <= 1'b0;
            smi_evt_o  <= 1'b0;
            serr_evt_o <= 1'b0;
            intr_evt_o <= 1'b0;
        end else begin
            cls_prev_r <= cls;
            sci_evt_o  <= class_hit(sci_mask_r, cls_rise);
            smi_evt_o  <= class_hit(smi_mask_r, cls_rise);
            serr_evt_o <= class_hit(serr_mask_r, cls_rise);
            intr_evt_o <= class_hit(intr_mask_r, cls_rise);
        end
    end

    // Sticky interrupt status; a new trip in the clearing cycle survives.
    logic trip_first_prev_r;
    logic trip_second_prev_r;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;

    assign irq_set[`ETTC_IRQ_FIRST_BIT]  = trip_first & ~trip_first_prev_r;
    assign irq_set[`ETTC_IRQ_SECOND_BIT] = trip_second & ~trip_second_prev_r;
    assign irq_clr = wr_clr ? rif.wdata[1:0] : 2'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trip_first_prev_r  <= 1'b0;
            trip_second_prev_r <= 1'b0;
            irq_stat_r         <= `ETTC_IRQ_RST;
        end else begin
            trip_first_prev_r  <= trip_first;
            trip_second_prev_r <= trip_second;
            irq_stat_r         <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    // The line follows the status as it stands after this edge, so a clear
    // drops it at once while a trip in the same cycle still raises it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
        end
    end

    // Read multiplexer. The trip indicators show the synchronised pin level
    // even while the inputs are disabled, so software can watch a sensor
    // before it commits the one-time lock.
    ettc_byte_t ctrl_rd;
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[`ETTC_EN_BIT]       = enable_r;
        ctrl_rd[`ETTC_THR_TYPE_BIT] = thr_type_r;
        ctrl_rd[`ETTC_ACT2_BIT]     = act2_r;
        ctrl_rd[`ETTC_ACT1_BIT]     = act1_r;
        ctrl_rd[`ETTC_TI0_BIT]   = raw_first;
        ctrl_rd[`ETTC_TI1_BIT]   = raw_second;
        ctrl_rd[`ETTC_ROUTE_BIT] = route_r;
    end

    always_comb begin
        if (rif.addr == reg_addr(`ETTC_CTRL_IDX)) begin
            rif.rdata = ctrl_rd;
        end else if (rif.addr == reg_addr(`ETTC_SCI_MASK_IDX)) begin
            rif.rdata = sci_mask_r;
        end else if (rif.addr == reg_addr(`ETTC_SMI_MASK_IDX)) begin
            rif.rdata = smi_mask_r;
        end else if (rif.addr == reg_addr(`ETTC_SERR_MASK_IDX)) begin
            rif.rdata = serr_mask_r;
        end else if (rif.addr == reg_addr(`ETTC_INTR_MASK_IDX)) begin
            rif.rdata = intr_mask_r;
        end else if (rif.addr == reg_addr(`ETTC_IRQ_STAT_IDX)) begin
            rif.rdata = {6'h00, irq_stat_r};
        end else if (rif.addr == reg_addr(`ETTC_IRQ_EN_IDX)) begin
            rif.rdata = {6'h00, irq_en_r};
        end else begin
            rif.rdata = 8'h00;
        end
    end

endmodule

`default_nettype wire

// file: ettc_top_sva.sv
// Concurrent checks on the ports of the external trip control.
`include "ettc_params.svh"
`timescale 1ns/10ps
`default_nettype none

module ettc_top_sva
    import ettc_pkg::*;
#(
    parameter int AW = 16
) (
    // Clock, reset and bus
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [AW-1:0] wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    input  wire logic [31:0]   wb_dat_o,
    input  wire logic          wb_ack_o,
    // Pins and throttle requests
    input  wire logic          ext_trip_pin_first_n_i,
    input  wire logic          ext_trip_pin_second_n_i,
    input  wire logic          int_mem_throttle_i,
    input  wire logic          int_ctl_throttle_i,
    input  wire logic          mem_throttle_o,
    input  wire logic          ctl_throttle_o,
    // Trip classes, events and interrupt
    input  wire ettc_class_t   sensor1_trip_o,
    input  wire ettc_class_t   sensor2_trip_o,
    input  wire logic          sci_evt_o,
    input  wire logic          intr_evt_o,
    input  wire logic          irq_o
);
    logic ctl_sel;
    logic en_r;
    logic thr_type_r;
    logic rd_ctl_r;

    // Shadow of the enable and throttle type bits, so the checks know the mode.
    assign ctl_sel = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == AW'(4 * `ETTC_CTRL_IDX);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r       <= 1'b0;
            thr_type_r <= 1'b0;
        end else if (ctl_sel && wb_we_i && wb_sel_i[0]) begin
            en_r       <= en_r | wb_dat_i[`ETTC_EN_BIT];
            thr_type_r <= en_r ? thr_type_r : wb_dat_i[`ETTC_THR_TYPE_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_ctl_r <= 1'b0;
        end else begin
            rd_ctl_r <= ctl_sel && !wb_we_i;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence first_held;
        en_r && $fell(ext_trip_pin_first_n_i) ##1 (!ext_trip_pin_first_n_i) [*2];
    endsequence
    sequence second_held;
        en_r && $fell(ext_trip_pin_second_n_i) ##1 (!ext_trip_pin_second_n_i) [*2];
    endsequence

    a_first_trip_latency: assert property (
        first_held |=> (sensor1_trip_o | sensor2_trip_o) != 3'h0 && (mem_throttle_o || ctl_throttle_o))
        else $error("first trip had no effect in time");
    a_second_trip_latency: assert property (
        second_held |=> (sensor1_trip_o | sensor2_trip_o) != 3'h0)
        else $error("second trip had no effect in time");
    a_disabled_quiet: assert property (
        !en_r |-> sensor1_trip_o == 3'h0 && sensor2_trip_o == 3'h0 && !irq_o && !sci_evt_o)
        else $error("trip effect while disabled");
    a_route_exclusive: assert property (
        !((sensor1_trip_o != 3'h0) && (sensor2_trip_o != 3'h0)))
        else $error("both sensor sets carry trips");
    a_event_has_class: assert property (
        sci_evt_o || intr_evt_o |-> (sensor1_trip_o | sensor2_trip_o) != 3'h0)
        else $error("event without trip class");
    a_mem_or_internal: assert property (
        int_mem_throttle_i |=> mem_throttle_o) else $error("internal memory request lost");
    a_ctl_or_internal: assert property (
        int_ctl_throttle_i |=> ctl_throttle_o) else $error("internal controller request lost");
    a_type_memory: assert property (
        !$past(thr_type_r) && !$past(int_ctl_throttle_i) |-> !ctl_throttle_o)
        else $error("controller throttle with memory type");
    a_type_controller: assert property (
        $past(thr_type_r) && !$past(int_mem_throttle_i) |-> !mem_throttle_o)
        else $error("memory throttle with controller type");
    a_enable_readback: assert property (
        rd_ctl_r && wb_ack_o |-> wb_dat_o[7] == en_r && wb_dat_o[31:8] == 24'h0)
        else $error("enable bit read back wrong");
    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
endmodule

bind ettc_top ettc_top_sva #(.AW(AW)) u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_trip_pin_first_n_i,
    .ext_trip_pin_second_n_i, .int_mem_throttle_i, .int_ctl_throttle_i, .mem_throttle_o,
    .ctl_throttle_o, .sensor1_trip_o, .sensor2_trip_o, .sci_evt_o, .intr_evt_o, .irq_o);

`default_nettype wire

// file: ettc_wb_slave.sv
// Classic Wishbone slave front end that turns bus cycles into register strobes.
`timescale 1ns/10ps
`default_nettype none

module ettc_wb_slave #(
    parameter int AW = 16
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // Wishbone
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [AW-1:0] wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    // Register side
    ettc_reg_if.slv            rif
);
    import ettc_pkg::*;

    logic req;
    logic ack_r;
    logic [31:0] dat_r;

    // The ack is withheld in the cycle after it was given, so one request is
    // never answered twice while the master releases it.
    assign req        = wb_cyc_i & wb_stb_i & ~ack_r;
    assign rif.addr   = wb_adr_i;
    assign rif.wdata  = wb_dat_i[7:0];
    assign rif.wr_stb = req & wb_we_i & wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            dat_r <= {24'h00_0000, rif.rdata};
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

endmodule

`default_nettype wire

// file: testbench.sv
// Self-checking bench for the external trip control block.
`include "ettc_params.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end

module testbench;
    import ettc_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [15:0] wb_adr_i = 16'h0000;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, mem_throttle_o, ctl_throttle_o, irq_o;
    logic        sci_evt_o, smi_evt_o, serr_evt_o, intr_evt_o;
    logic        int_mem_throttle_i = 1'b0, int_ctl_throttle_i = 1'b0;
    logic        over_first = 1'b0, over_second = 1'b0;
    wire logic   ext_trip_pin_first_n_i, ext_trip_pin_second_n_i;
    ettc_class_t sensor1_trip_o, sensor2_trip_o;
    ettc_byte_t  scratch;
    int          n_fail = 0, n_tests = 0;

    ettc_top #(.AW(16)) uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_trip_pin_first_n_i,
        .ext_trip_pin_second_n_i, .int_mem_throttle_i, .int_ctl_throttle_i, .mem_throttle_o,
        .ctl_throttle_o, .sensor1_trip_o, .sensor2_trip_o, .sci_evt_o, .smi_evt_o,
        .serr_evt_o, .intr_evt_o, .irq_o);
    ettc_sensor_model sensors (.over_first_i(over_first), .over_second_i(over_second),
        .trip_first_n_o(ext_trip_pin_first_n_i), .trip_second_n_o(ext_trip_pin_second_n_i));

    always #12.5 clk_i = ~clk_i;

    task automatic report_and_stop();
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The request is held until ack is sampled high; only the watchdog ends a wait.
    task automatic wb_cycle(input logic we, input int idx, input int wd, output ettc_byte_t rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= 16'(4 * idx);
        wb_dat_i <= 32'(wd);
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input int idx, input int d);
        wb_cycle(1'b1, idx, d, scratch);
    endtask

    task automatic chk_reg(input int idx, input ettc_byte_t exp);
        ettc_byte_t v;
        wb_cycle(1'b0, idx, 0, v);
        `CHK(v, exp)
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Outputs follow a pin change at the third edge; event pulses stand for
    // just that one cycle, so the checks land right after it.
    task automatic pins(input logic f, input logic s);
        @(posedge clk_i);
        over_first  <= f;
        over_second <= s;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    task automatic chk_trip(input ettc_byte_t cfg, input logic [2:0] cls);
        `CHK(cfg[0] ? sensor2_trip_o : sensor1_trip_o, cls)
        `CHK(cfg[0] ? sensor1_trip_o : sensor2_trip_o, 3'h0)
        `CHK({mem_throttle_o, ctl_throttle_o}, cfg[6] ? 2'b01 : 2'b10)
        `CHK({sci_evt_o, smi_evt_o, serr_evt_o, intr_evt_o}, {cls, 1'b1})
    endtask

    task automatic t_reset_values();
        for (int i = 'h10EF; i <= 'h10F7; i++) chk_reg(i, 8'h00);
        wr('h10F7, 'hFF);
        chk_reg('h10F7, 8'h00);
        wr(`ETTC_SCI_MASK_IDX, 'hFF);
        chk_reg(`ETTC_SCI_MASK_IDX, 8'hFF);
    endtask

    task automatic t_disabled();
        wr(`ETTC_CTRL_IDX, 'h71);
        chk_reg(`ETTC_CTRL_IDX, 8'h71);
        pins(1'b1, 1'b1);
        `CHK({sensor1_trip_o, sensor2_trip_o, mem_throttle_o, ctl_throttle_o}, 8'h00)
        chk_reg(`ETTC_CTRL_IDX, 8'h7D);
        pins(1'b0, 1'b0);
        @(posedge clk_i);
        int_mem_throttle_i <= 1'b1;
        int_ctl_throttle_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        `CHK({mem_throttle_o, ctl_throttle_o}, 2'b11)
        @(posedge clk_i);
        int_mem_throttle_i <= 1'b0;
        int_ctl_throttle_i <= 1'b0;
    endtask

    task automatic t_combo(input ettc_byte_t cfg);
        logic [2:0] c1;
        logic [2:0] c2;
        c1 = cfg[`ETTC_ACT1_BIT] ? 3'b010 : 3'b100;
        c2 = cfg[`ETTC_ACT2_BIT] ? 3'b001 : 3'b010;
        do_reset();
        chk_reg(`ETTC_CTRL_IDX, 8'h00);
        wr(`ETTC_SCI_MASK_IDX, 'h20);
        wr(`ETTC_SMI_MASK_IDX, 'h10);
        wr(`ETTC_SERR_MASK_IDX, 'h01);
        wr(`ETTC_INTR_MASK_IDX, 'h31);
        wr(`ETTC_IRQ_EN_IDX, 'h01);
        wr(`ETTC_CTRL_IDX, 'h80 | cfg);
        pins(1'b1, 1'b0);
        chk_trip(cfg, c1);
        `CHK(irq_o, 1'b1)
        chk_reg(`ETTC_IRQ_STAT_IDX, 8'h01);
        chk_reg(`ETTC_CTRL_IDX, 8'h88 | cfg);
        wr(`ETTC_IRQ_CLR_IDX, 'h01);
        #1;
        `CHK(irq_o, 1'b0)
        pins(1'b0, 1'b0);
        pins(1'b0, 1'b1);
        chk_trip(cfg, c2);
        `CHK(irq_o, 1'b0)
        chk_reg(`ETTC_IRQ_STAT_IDX, 8'h02);
        wr(`ETTC_CTRL_IDX, ~cfg & 8'h7F);
        chk_reg(`ETTC_CTRL_IDX, 8'h84 | cfg);
        pins(1'b0, 1'b0);
    endtask

    initial begin
        #(25 * 20000);
        n_fail++;
        report_and_stop();
    end

    initial begin
        do_reset();
        t_reset_values();
        t_disabled();
        for (int i = 0; i < 16; i++) t_combo(8'({1'b0, i[3:1], 3'b000, i[0]}));
        report_and_stop();
    end
endmodule

`default_nettype wire
